// ### design/spf_consts.svh
// constants for the serial pin function and clock direction block
// assumes a single 250 MHz system clock; included by bare name
`ifndef SPF_CONSTS_SVH
`define SPF_CONSTS_SVH

// system clock period
`define SPF_CLK_PERIOD_NS     4
// silence on frame sync after which the pll is taken as unlocked
`define SPF_SYNC_LOSS_NS      100000
// longest time, rounds down
`define SPF_SYNC_LOSS_CYC     (`SPF_SYNC_LOSS_NS / `SPF_CLK_PERIOD_NS)
// delay from pll unlock to bus reset
`define SPF_UNLOCK_DLY_NS     1000000
// least time, rounds up
`define SPF_UNLOCK_DLY_CYC    ((`SPF_UNLOCK_DLY_NS + `SPF_CLK_PERIOD_NS - 1) / `SPF_CLK_PERIOD_NS)
// bit clock half period in system cycles at normal frame rate
`define SPF_BCLK_HALF_DIV     8'h0A
// mic clock half period in system cycles
`define SPF_MIC_HALF_DIV      8'h28
// width of the watchdog counter
`define SPF_WD_W              20
// width of the bit counter inside a frame
`define SPF_BIT_W             11
// channel sizes in bits
`define SPF_CH16_BITS         6'h10
`define SPF_CH24_BITS         6'h18
`define SPF_CH32_BITS         6'h20
// one-hot monitor state codes
`define SPF_ST_IDLE           4'h1
`define SPF_ST_ACQ            4'h2
`define SPF_ST_LOCK           4'h4
`define SPF_ST_LOST           4'h8

`endif

// ### design/spf_pin_mux.sv
// serial pin function selection and frame sync / bit clock direction
// assumes core audio, gpio and spi logic on the same clock; pads resolve o/oe outside
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - during reset every pin undriven and its input buffer off
// - pin zero: receive lane zero, mic input zero, or general pin zero
// - pin one: receive lane one or transmit three, mic one, or general one
// - pin two: receive lane two or transmit lane two
// - pin two free of audio: alternate select input or select output one
// - pin two general pin only when neither audio nor select
// - frame sync marks the start of each audio frame
// - main node: frame sync is the pll reference for all clocking
// - main node: frame sync silence unlocks pll, bus resets after delay
// - subordinate: device drives frame sync at configured frame rate
// - paired mode subordinate: frame sync is an input from partner
// - subordinate: device drives bit clock from rate alone; tdm mode and size set frame length
// - subordinate: bit-clock pin may carry the mic clock instead
// - paired mode subordinate: bit clock is an input from partner
module spf_pin_mux
   import spf_pkg::*;
#(
   parameter int SYNC_LOSS_CYC  = `SPF_SYNC_LOSS_CYC,
   parameter int UNLOCK_DLY_CYC = `SPF_UNLOCK_DLY_CYC,
   parameter logic [7:0] BCLK_HALF_DIV = `SPF_BCLK_HALF_DIV,
   parameter logic [7:0] MIC_HALF_DIV  = `SPF_MIC_HALF_DIV
) (
   input  wire logic       CLK_SYS_I,
   input  wire logic       SYS_RST_I,
   // configuration
   input  wire spf_cfg_t   CFG_I,
   input  wire logic       CFG_WR_I,
   output logic            CFG_VALID_O,
   // serial pins
   input  wire logic [2:0] SERIAL_PIN_I,
   output logic      [2:0] SERIAL_PIN_O,
   output logic      [2:0] SERIAL_PIN_OE_O,
   output logic      [2:0] SERIAL_PIN_IE_O,
   // frame sync and bit clock pins
   input  wire logic       FRAME_SYNC_I,
   output logic            FRAME_SYNC_O,
   output logic            FRAME_SYNC_OE_O,
   output logic            FRAME_SYNC_IE_O,
   input  wire logic       BIT_CLOCK_I,
   output logic            BIT_CLOCK_O,
   output logic            BIT_CLOCK_OE_O,
   output logic            BIT_CLOCK_IE_O,
   // core side
   output logic      [2:0] RECEIVE_LANE_O,
   input  wire logic       TRANSMIT_LANE_TWO_I,
   input  wire logic       TRANSMIT_LANE_THREE_I,
   output logic      [1:0] MIC_INPUT_O,
   input  wire logic [2:0] GENERAL_PIN_OUT_I,
   input  wire logic [2:0] GENERAL_PIN_OUT_EN_I,
   output logic      [2:0] GENERAL_PIN_IN_O,
   output logic            ALT_TARGET_SELECT_IN_O,
   input  wire logic       TARGET_SELECT_OUT_ONE_I,
   output logic            PLL_REF_O,
   output logic            BIT_CLOCK_CORE_O,
   output logic            FRAME_START_O,
   output logic            PLL_LOCK_O,
   output logic            BUS_RST_O
);

   spf_state_t r_r;
   spf_state_t r_nxt;
   logic [4:0] pin_s;
   logic [2:0] sio_s;
   logic       fs_s;
   logic       bc_s;

   //////////////////////////////////////////////////////////////////////////
   // pin input synchronisers, nothing reads the first stage
   spf_sync2 #(
      .W (5)
   ) u_sync (
      .CLK_SYS_I (CLK_SYS_I),
      .SYS_RST_I (SYS_RST_I),
      .d_i       ({BIT_CLOCK_I, FRAME_SYNC_I, SERIAL_PIN_I}),
      .q_o       (pin_s)
   );

   assign sio_s = pin_s[2:0];
   assign fs_s  = pin_s[3];
   assign bc_s  = pin_s[4];

   //////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      logic                  is_main;
      logic                  drive_clk;
      logic [7:0]            half;
      logic [5:0]            ch_bits;
      logic [`SPF_BIT_W-1:0] bits;
      logic                  edge_s;
      is_main   = 1'b0;
      drive_clk = 1'b0;
      half      = BCLK_HALF_DIV;
      ch_bits   = `SPF_CH32_BITS;
      bits      = '0;
      edge_s    = 1'b0;
      r_nxt     = r_r;

      // one-cycle pulses and per-cycle pin state default to idle
      r_nxt.frame_start = 1'b0;
      r_nxt.bus_rst     = 1'b0;
      r_nxt.sio_o       = '0;
      r_nxt.sio_oe      = '0;
      r_nxt.sio_ie      = '0;
      r_nxt.fs_o        = 1'b0;
      r_nxt.fs_oe       = 1'b0;
      r_nxt.fs_ie       = 1'b0;
      r_nxt.bc_o        = 1'b0;
      r_nxt.bc_oe       = 1'b0;
      r_nxt.bc_ie       = 1'b0;
      r_nxt.rx          = '0;
      r_nxt.mic         = '0;
      r_nxt.gpin        = '0;
      r_nxt.alt_sel     = 1'b0;

      // configuration held until rewritten; pins wait for it
      if (CFG_WR_I) begin
         r_nxt.cfg    = CFG_I;
         r_nxt.cfg_ok = 1'b1;
      end

      is_main   = r_r.cfg_ok && (r_r.cfg.role == SPF_ROLE_MAIN);
      drive_clk = r_r.cfg_ok && (r_r.cfg.role == SPF_ROLE_SUB) && !r_r.cfg.paired;

      // serial pin functions, only once configured
      if (r_r.cfg_ok) begin
         // pin zero
         r_nxt.sio_ie[0] = 1'b1;
         if (r_r.cfg.mic_en) begin
            r_nxt.mic[0] = sio_s[0];
         end else if (r_r.cfg.fn0 == SPF_P0_RX0) begin
            r_nxt.rx[0] = sio_s[0];
         end else begin
            r_nxt.gpin[0]   = sio_s[0];
            r_nxt.sio_o[0]  = GENERAL_PIN_OUT_I[0];
            r_nxt.sio_oe[0] = GENERAL_PIN_OUT_EN_I[0];
         end
         // pin one; mic input wins over the lane choice
         r_nxt.sio_ie[1] = 1'b1;
         if (r_r.cfg.mic_en) begin
            r_nxt.mic[1] = sio_s[1];
         end else begin
            case (r_r.cfg.fn1)
               SPF_P1_RX1: begin
                  r_nxt.rx[1] = sio_s[1];
               end
               SPF_P1_TX3: begin
                  r_nxt.sio_ie[1] = 1'b0;
                  r_nxt.sio_o[1]  = TRANSMIT_LANE_THREE_I;
                  r_nxt.sio_oe[1] = 1'b1;
               end
               default: begin
                  r_nxt.gpin[1]   = sio_s[1];
                  r_nxt.sio_o[1]  = GENERAL_PIN_OUT_I[1];
                  r_nxt.sio_oe[1] = GENERAL_PIN_OUT_EN_I[1];
               end
            endcase
         end
         // pin two; exclusive select keeps general use last in line
         r_nxt.sio_ie[2] = 1'b1;
         case (r_r.cfg.fn2)
            SPF_P2_RX2: begin
               r_nxt.rx[2] = sio_s[2];
            end
            SPF_P2_TX2: begin
               r_nxt.sio_ie[2] = 1'b0;
               r_nxt.sio_o[2]  = TRANSMIT_LANE_TWO_I;
               r_nxt.sio_oe[2] = 1'b1;
            end
            SPF_P2_ALT_SEL: begin
               r_nxt.alt_sel = sio_s[2];
            end
            SPF_P2_SEL_OUT1: begin
               r_nxt.sio_ie[2] = 1'b0;
               r_nxt.sio_o[2]  = TARGET_SELECT_OUT_ONE_I;
               r_nxt.sio_oe[2] = 1'b1;
            end
            default: begin
               r_nxt.gpin[2]   = sio_s[2];
               r_nxt.sio_o[2]  = GENERAL_PIN_OUT_I[2];
               r_nxt.sio_oe[2] = GENERAL_PIN_OUT_EN_I[2];
            end
         endcase
      end

      //////////////////////////////////////////////////////////////////////
      // subordinate clock generation; rate scales the bit clock divider
      case (r_r.cfg.rate)
         SPF_RATE_INC: half = {1'b0, BCLK_HALF_DIV[7:1]};
         SPF_RATE_RED: half = {BCLK_HALF_DIV[6:0], 1'b0};
         default:      half = BCLK_HALF_DIV;
      endcase
      if (half == 8'h00) begin
         half = 8'h01;                  // never below one cycle
      end
      case (r_r.cfg.chan)
         SPF_CH_16: ch_bits = `SPF_CH16_BITS;
         SPF_CH_24: ch_bits = `SPF_CH24_BITS;
         default:   ch_bits = `SPF_CH32_BITS;
      endcase
      bits = `SPF_BIT_W'({5'h00, ch_bits} << r_r.cfg.slots_log2);

      if (drive_clk) begin
         r_nxt.div_cnt = r_r.div_cnt + 8'h01;
         if (r_r.div_cnt >= half - 8'h01) begin
            r_nxt.div_cnt = 8'h00;
            r_nxt.bclk_q  = ~r_r.bclk_q;
            // advance a bit on each falling edge of the bit clock
            if (r_r.bclk_q) begin
               if (r_r.bit_cnt >= bits - `SPF_BIT_W'(1)) begin
                  r_nxt.bit_cnt     = '0;
                  r_nxt.fsync_q     = 1'b1;
                  r_nxt.frame_start = 1'b1;
               end else begin
                  r_nxt.bit_cnt = r_r.bit_cnt + `SPF_BIT_W'(1);
                  r_nxt.fsync_q = 1'b0;
               end
            end
         end
         // mic clock runs independently so mic and tdm rates can differ
         r_nxt.mic_cnt = r_r.mic_cnt + 8'h01;
         if (r_r.mic_cnt >= MIC_HALF_DIV - 8'h01) begin
            r_nxt.mic_cnt = 8'h00;
            r_nxt.mic_q   = ~r_r.mic_q;
         end
         r_nxt.fs_o      = r_r.fsync_q;
         r_nxt.fs_oe     = 1'b1;
         r_nxt.bc_o      = r_r.cfg.mic_clk_sel ? r_r.mic_q : r_r.bclk_q;
         r_nxt.bc_oe     = 1'b1;
         r_nxt.bclk_core = r_r.bclk_q;
         r_nxt.pll_ref   = r_r.fsync_q;
      end else begin
         r_nxt.div_cnt = 8'h00;
         r_nxt.bclk_q  = 1'b0;
         r_nxt.fsync_q = 1'b0;
         r_nxt.bit_cnt = '0;
         r_nxt.mic_cnt = 8'h00;
         r_nxt.mic_q   = 1'b0;
         // main or paired: both clock pins are inputs
         if (r_r.cfg_ok) begin
            r_nxt.fs_ie     = 1'b1;
            r_nxt.bc_ie     = 1'b1;
            r_nxt.pll_ref   = fs_s;
            r_nxt.bclk_core = bc_s;
            r_nxt.frame_start = fs_s & ~r_r.fs_prev;
         end else begin
            r_nxt.pll_ref   = 1'b0;
            r_nxt.bclk_core = 1'b0;
         end
      end
      r_nxt.fs_prev = fs_s;

      //////////////////////////////////////////////////////////////////////
      // frame sync watchdog on the main node
      edge_s = fs_s ^ r_r.fs_prev;
      case (r_r.mon)
         SPF_IDLE: begin
            r_nxt.wd_cnt   = '0;
            r_nxt.pll_lock = 1'b0;
            if (is_main) begin
               r_nxt.mon = SPF_ACQ;
            end
         end
         SPF_ACQ: begin
            r_nxt.wd_cnt = '0;
            if (edge_s) begin
               r_nxt.mon      = SPF_LOCK;
               r_nxt.pll_lock = 1'b1;
            end
         end
         SPF_LOCK: begin
            r_nxt.wd_cnt = edge_s ? '0 : r_r.wd_cnt + `SPF_WD_W'(1);
            if (!edge_s && r_r.wd_cnt >= `SPF_WD_W'(SYNC_LOSS_CYC - 1)) begin
               r_nxt.mon      = SPF_LOST;
               r_nxt.pll_lock = 1'b0;
               r_nxt.wd_cnt   = '0;
            end
         end
         SPF_LOST: begin
            r_nxt.wd_cnt = r_r.wd_cnt + `SPF_WD_W'(1);
            if (r_r.wd_cnt >= `SPF_WD_W'(UNLOCK_DLY_CYC - 1)) begin
               r_nxt.bus_rst = 1'b1;
               r_nxt.wd_cnt  = '0;
               r_nxt.mon     = SPF_ACQ;
            end
         end
         default: begin
            r_nxt.mon = SPF_IDLE;
         end
      endcase
      if (!is_main) begin
         r_nxt.mon      = SPF_IDLE;
         r_nxt.pll_lock = 1'b0;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // state register; reset leaves all pins undriven with inputs off
   always_ff @(posedge CLK_SYS_I) begin
      if (SYS_RST_I) begin
         r_r     <= '0;
         r_r.mon <= SPF_IDLE;
      end else begin
         r_r <= r_nxt;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // outputs straight from the state register
   assign CFG_VALID_O            = r_r.cfg_ok;
   assign SERIAL_PIN_O           = r_r.sio_o;
   assign SERIAL_PIN_OE_O        = r_r.sio_oe;
   assign SERIAL_PIN_IE_O        = r_r.sio_ie;
   assign FRAME_SYNC_O           = r_r.fs_o;
   assign FRAME_SYNC_OE_O        = r_r.fs_oe;
   assign FRAME_SYNC_IE_O        = r_r.fs_ie;
   assign BIT_CLOCK_O            = r_r.bc_o;
   assign BIT_CLOCK_OE_O         = r_r.bc_oe;
   assign BIT_CLOCK_IE_O         = r_r.bc_ie;
   assign RECEIVE_LANE_O         = r_r.rx;
   assign MIC_INPUT_O            = r_r.mic;
   assign GENERAL_PIN_IN_O       = r_r.gpin;
   assign ALT_TARGET_SELECT_IN_O = r_r.alt_sel;
   assign PLL_REF_O              = r_r.pll_ref;
   assign BIT_CLOCK_CORE_O       = r_r.bclk_core;
   assign FRAME_START_O          = r_r.frame_start;
   assign PLL_LOCK_O             = r_r.pll_lock;
   assign BUS_RST_O              = r_r.bus_rst;
endmodule // spf_pin_mux

// ### design/spf_pkg.sv
// types for the serial pin function and clock direction block
// assumes spf_consts.svh is on the include path
`include "spf_consts.svh"

package spf_pkg;

   typedef enum logic {SPF_ROLE_MAIN = 1'b0, SPF_ROLE_SUB = 1'b1} spf_role_t;
   typedef enum logic [1:0] {SPF_RATE_NORM = 2'h0, SPF_RATE_INC = 2'h1,
                             SPF_RATE_RED = 2'h2} spf_rate_t;
   typedef enum logic [1:0] {SPF_CH_16 = 2'h0, SPF_CH_24 = 2'h1, SPF_CH_32 = 2'h2} spf_chan_t;
   typedef enum logic {SPF_P0_RX0 = 1'b0, SPF_P0_GPIO = 1'b1} spf_fn0_t;
   typedef enum logic [1:0] {SPF_P1_RX1 = 2'h0, SPF_P1_TX3 = 2'h1,
                             SPF_P1_GPIO = 2'h2} spf_fn1_t;
   typedef enum logic [2:0] {SPF_P2_RX2 = 3'h0, SPF_P2_TX2 = 3'h1, SPF_P2_ALT_SEL = 3'h2,
                             SPF_P2_SEL_OUT1 = 3'h3, SPF_P2_GPIO = 3'h4} spf_fn2_t;
   typedef enum logic [3:0] {SPF_IDLE = `SPF_ST_IDLE, SPF_ACQ = `SPF_ST_ACQ,
                             SPF_LOCK = `SPF_ST_LOCK, SPF_LOST = `SPF_ST_LOST} spf_mon_t;

   // configuration loaded by one write strobe
   typedef struct packed {
      spf_role_t  role;
      logic       paired;       // paired parallel-bus mode
      logic       mic_en;       // pulse-density inputs enabled
      logic       mic_clk_sel;  // bit-clock pin carries mic clock
      spf_fn0_t   fn0;
      spf_fn1_t   fn1;
      spf_fn2_t   fn2;
      spf_rate_t  rate;
      logic [2:0] slots_log2;   // slots per frame = 2**slots_log2
      spf_chan_t  chan;
   } spf_cfg_t;

   // whole state of the top module
   typedef struct packed {
      spf_cfg_t               cfg;
      logic                   cfg_ok;
      logic [2:0]             sio_o;
      logic [2:0]             sio_oe;
      logic [2:0]             sio_ie;
      logic                   fs_o;
      logic                   fs_oe;
      logic                   fs_ie;
      logic                   bc_o;
      logic                   bc_oe;
      logic                   bc_ie;
      logic [2:0]             rx;
      logic [1:0]             mic;
      logic [2:0]             gpin;
      logic                   alt_sel;
      logic                   pll_ref;
      logic                   bclk_core;
      logic                   frame_start;
      logic                   pll_lock;
      logic                   bus_rst;
      spf_mon_t               mon;
      logic [`SPF_WD_W-1:0]   wd_cnt;
      logic                   fs_prev;
      logic [7:0]             div_cnt;
      logic                   bclk_q;
      logic                   fsync_q;
      logic [`SPF_BIT_W-1:0]  bit_cnt;
      logic [7:0]             mic_cnt;
      logic                   mic_q;
   } spf_state_t;

endpackage

// ### design/spf_sync2.sv
// two flip-flop synchroniser for a group of pin inputs
// assumes inputs are asynchronous to CLK_SYS_I
`timescale 1ns/1ps

module spf_sync2 #(
   parameter int W = 5
) (
   input  wire logic         CLK_SYS_I,
   input  wire logic         SYS_RST_I,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stab;
   } spf_sync_st_t;

   spf_sync_st_t st_r;
   spf_sync_st_t st_nxt;

   // first stage feeds only the second
   always_comb begin
      st_nxt      = st_r;
      st_nxt.meta = d_i;
      st_nxt.stab = st_r.meta;
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (SYS_RST_I) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q_o = st_r.stab;
endmodule // spf_sync2

// ### test/spf_host_model.sv
// host side tdm master for main-node runs: drives frame sync and bit clock
// assumes run_i from the bench starts and silences both pins
`timescale 1ns/1ps

module spf_host_model #(
   parameter int  BITS    = 16,
   parameter real HALF_NS = 4.0
) (
   input  wire logic run_i,
   output logic      fs_o,
   output logic      bc_o
);
   int bit_idx;

   // free running at an unrelated phase; both pins park low when stopped
   initial begin
      fs_o = 1'b0;
      bc_o = 1'b0;
      bit_idx = 0;
      #1.3;
      forever begin
         #(HALF_NS);
         bc_o = run_i & ~bc_o;
         if (!bc_o)
            bit_idx = (bit_idx + 1) % BITS;
         fs_o = run_i && bit_idx == 0;
      end
   end
endmodule // spf_host_model

// ### test/spf_pin_mux_asserts.sv
// port checks for spf_pin_mux
// assumes one system clock and a bind from the bench
`timescale 1ns/1ps

module spf_pin_mux_asserts
   import spf_pkg::*;
#(
   parameter int SYNC_LOSS_CYC  = 20,
   parameter int UNLOCK_DLY_CYC = 10
) (
   input wire logic       CLK_SYS_I,
   input wire logic       SYS_RST_I,
   input wire spf_cfg_t   CFG_I,
   input wire logic       CFG_WR_I,
   input wire logic       CFG_VALID_O,
   input wire logic [2:0] SERIAL_PIN_OE_O,
   input wire logic [2:0] SERIAL_PIN_IE_O,
   input wire logic       FRAME_SYNC_OE_O,
   input wire logic       FRAME_SYNC_IE_O,
   input wire logic       BIT_CLOCK_OE_O,
   input wire logic       BIT_CLOCK_IE_O,
   input wire logic       PLL_REF_O,
   input wire logic       PLL_LOCK_O,
   input wire logic       BUS_RST_O
);
   // slack for the synchroniser and a late last edge
   localparam int LOST_MAX = SYNC_LOSS_CYC + 8;
   localparam int RST_LO   = UNLOCK_DLY_CYC - 2;
   localparam int RST_HI   = UNLOCK_DLY_CYC + 3;
   logic [19:0] quiet_r;
   logic [19:0] gap_r;
   wire         pins_off = {SERIAL_PIN_OE_O, SERIAL_PIN_IE_O, FRAME_SYNC_OE_O,
                            FRAME_SYNC_IE_O, BIT_CLOCK_OE_O, BIT_CLOCK_IE_O} == 10'h000;
   wire         clk_in   = !FRAME_SYNC_OE_O && FRAME_SYNC_IE_O && !BIT_CLOCK_OE_O && BIT_CLOCK_IE_O;

   // cycles since frame sync rose and since unlock
   always_ff @(posedge CLK_SYS_I) begin
      if (SYS_RST_I || $rose(PLL_REF_O))
         quiet_r <= 20'h00000;
      else
         quiet_r <= quiet_r + 20'h00001;
      if (SYS_RST_I || PLL_LOCK_O)
         gap_r <= 20'h00000;
      else
         gap_r <= gap_r + 20'h00001;
   end

   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (SYS_RST_I);

   // config strobe of one role, then a quiet cycle
   sequence s_wr(logic sub, logic pair);
      CFG_WR_I && (CFG_I.role == SPF_ROLE_SUB) == sub && CFG_I.paired == pair ##1 !CFG_WR_I;
   endsequence

   chk_reset_quiet: assert property (disable iff (1'b0) SYS_RST_I |=> pins_off)
      else $error("pins active right after reset");
   chk_hold_unconfig: assert property (!CFG_VALID_O |=> pins_off)
      else $error("pins active before config");
   chk_cfg_taken: assert property (CFG_WR_I |=> CFG_VALID_O)
      else $error("config strobe not taken");
   chk_main_inputs: assert property (s_wr(1'b0, 1'b0) |=> clk_in)
      else $error("main node clock pins not inputs");
   chk_sub_drives: assert property (s_wr(1'b1, 1'b0) |=> FRAME_SYNC_OE_O && BIT_CLOCK_OE_O)
      else $error("subordinate clock pins not driven");
   chk_paired_inputs: assert property (s_wr(1'b1, 1'b1) |=> clk_in)
      else $error("paired clock pins not inputs");
   chk_lock_drops: assert property (quiet_r > LOST_MAX |-> !PLL_LOCK_O)
      else $error("lock held on silent frame sync");
   chk_unlock_delay: assert property (BUS_RST_O |-> gap_r >= RST_LO && gap_r <= RST_HI)
      else $error("bus reset off its unlock delay");
   chk_rst_pulse: assert property (BUS_RST_O |=> !BUS_RST_O [*3])
      else $error("bus reset longer than one cycle");
endmodule // spf_pin_mux_asserts

// ### test/spf_pin_mux_bench.sv
// self-checking bench for spf_pin_mux
// assumes spf_pkg, host model and checker compiled first
`timescale 1ns/1ps
`include "spf_consts.svh"

module spf_pin_mux_bench
   import spf_pkg::*;
;
   localparam int SL = 40;
   localparam int UD = 10;
   logic       clk, rst, wr, run, tx2, tx3, sel1, vld, fs_o, fs_oe, fs_ie;
   logic       bc_o, bc_oe, bc_ie, alt, pref, bcc, fst, lock, brst;
   logic [2:0] pin_i, p_o, p_oe, p_ie, rx, gp_o, gp_en, gp_in;
   logic [1:0] mic;
   spf_cfg_t   cfg;
   wire        fs_h, bc_h;
   wire  [4:0] lvl_v = {brst, lock, fst, bc_o, fs_o};
   wire  [9:0] en_v  = {p_oe, p_ie, fs_oe, fs_ie, bc_oe, bc_ie};
   int         mismatches = 0, compares = 0;

   spf_host_model #(.BITS(16), .HALF_NS(4.0)) u_host (.run_i(run), .fs_o(fs_h), .bc_o(bc_h));

   spf_pin_mux #(.SYNC_LOSS_CYC(SL), .UNLOCK_DLY_CYC(UD)) uut (
      .CLK_SYS_I(clk), .SYS_RST_I(rst), .CFG_I(cfg), .CFG_WR_I(wr), .CFG_VALID_O(vld),
      .SERIAL_PIN_I(pin_i), .SERIAL_PIN_O(p_o), .SERIAL_PIN_OE_O(p_oe), .SERIAL_PIN_IE_O(p_ie),
      .FRAME_SYNC_I(fs_h), .FRAME_SYNC_O(fs_o), .FRAME_SYNC_OE_O(fs_oe), .FRAME_SYNC_IE_O(fs_ie),
      .BIT_CLOCK_I(bc_h), .BIT_CLOCK_O(bc_o), .BIT_CLOCK_OE_O(bc_oe), .BIT_CLOCK_IE_O(bc_ie),
      .RECEIVE_LANE_O(rx), .TRANSMIT_LANE_TWO_I(tx2), .TRANSMIT_LANE_THREE_I(tx3),
      .MIC_INPUT_O(mic), .GENERAL_PIN_OUT_I(gp_o), .GENERAL_PIN_OUT_EN_I(gp_en),
      .GENERAL_PIN_IN_O(gp_in), .ALT_TARGET_SELECT_IN_O(alt), .TARGET_SELECT_OUT_ONE_I(sel1),
      .PLL_REF_O(pref), .BIT_CLOCK_CORE_O(bcc), .FRAME_START_O(fst), .PLL_LOCK_O(lock),
      .BUS_RST_O(brst));

   // 250 MHz system clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // bounded wait for a level; a hang ends the run
   task automatic wait_lvl(input int s, input logic lvl, inout int n);
      for (int k = 0; lvl_v[s] !== lvl; k++) begin
         if (k > 3000) begin
            mismatches++;
            $display("wrong value wait %0d expected %b seen timeout", s, lvl);
            test_done();
         end
         @(negedge clk);
         n++;
      end
   endtask

   // rising to rising, first partial period skipped
   task automatic period(input int s, output int n);
      repeat (2) begin
         n = 0;
         wait_lvl(s, 1'b0, n);
         wait_lvl(s, 1'b1, n);
      end
   endtask

   function automatic int half_of(input spf_rate_t r);
      half_of = r == SPF_RATE_INC ? `SPF_BCLK_HALF_DIV / 2 :
                r == SPF_RATE_RED ? `SPF_BCLK_HALF_DIV * 2 : `SPF_BCLK_HALF_DIV;
   endfunction

   function automatic int bits_of(input spf_cfg_t c);
      bits_of = (c.chan == SPF_CH_16 ? 16 : c.chan == SPF_CH_24 ? 24 : 32) << c.slots_log2;
   endfunction

   task automatic do_reset();
      rst = 1'b1;
      repeat (16) @(negedge clk);
      chk("pins in reset", 12'h000, 12'(en_v));
      rst = 1'b0;
      repeat (5) @(negedge clk);
      chk("pins unconfigured", 12'h000, 12'(en_v));
   endtask

   task automatic cfg_put(input spf_cfg_t c);
      cfg = c;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
      repeat (2) @(negedge clk);
   endtask

   // random levels under one function choice
   task automatic pin_case(input spf_cfg_t c);
      logic [2:0] eoe, eo, erx, eie, egp;
      logic [1:0] emic;
      logic       ealt;
      cfg_put(c);
      pin_i = 3'($urandom);
      gp_o = 3'($urandom);
      gp_en = 3'($urandom);
      {tx2, tx3, sel1} = 3'($urandom);
      repeat (4) @(negedge clk);
      {eoe, eo, erx, emic, ealt, egp} = '0;
      eie = 3'h7;
      if (c.mic_en)
         emic = pin_i[1:0];
      else begin
         if (c.fn0 == SPF_P0_RX0)
            erx[0] = pin_i[0];
         else
            {eoe[0], eo[0], egp[0]} = {gp_en[0], gp_o[0], pin_i[0]};
         case (c.fn1)
            SPF_P1_RX1: erx[1] = pin_i[1];
            SPF_P1_TX3: {eoe[1], eo[1], eie[1]} = {1'b1, tx3, 1'b0};
            default: {eoe[1], eo[1], egp[1]} = {gp_en[1], gp_o[1], pin_i[1]};
         endcase
      end
      case (c.fn2)
         SPF_P2_RX2: erx[2] = pin_i[2];
         SPF_P2_TX2: {eoe[2], eo[2], eie[2]} = {1'b1, tx2, 1'b0};
         SPF_P2_ALT_SEL: ealt = pin_i[2];
         SPF_P2_SEL_OUT1: {eoe[2], eo[2], eie[2]} = {1'b1, sel1, 1'b0};
         default: {eoe[2], eo[2], egp[2]} = {gp_en[2], gp_o[2], pin_i[2]};
      endcase
      chk("pin drive", 12'({eoe, eo & eoe, eie}), 12'({p_oe, p_o & eoe, p_ie}));
      chk("core lanes", 12'({erx, emic, ealt, egp}), 12'({rx, mic, alt, gp_in}));
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      spf_cfg_t c;
      int       i, n;
      void'($urandom(32'h5F49C392));
      cfg = '0;
      {wr, tx2, tx3, sel1, pin_i, gp_o, gp_en} = '0;
      run = 1'b1;
      do_reset();
      // all pin function codes, mic enable both ways first
      for (i = 0; i < 15; i++) begin
         c = '0;
         c.fn0 = spf_fn0_t'(i % 2);
         c.fn1 = spf_fn1_t'(i % 3);
         c.fn2 = spf_fn2_t'(i % 5);
         c.mic_en = i < 2 ? ~i[0] : 1'($urandom);
         pin_case(c);
      end
      chk("pll lock", 12'h001, 12'(lock));
      n = 0;
      repeat (320) begin
         @(negedge clk);
         n += int'(fst);
      end
      chk("frame starts", 12'h00A, 12'(n));
      // silence the host after a frame start
      n = 0;
      wait_lvl(2, 1'b1, n);
      run = 1'b0;
      n = 0;
      wait_lvl(3, 1'b0, n);
      chk("lock loss delay", 12'h001, 12'(n >= SL - 4 && n <= SL + 8));
      n = 0;
      wait_lvl(4, 1'b1, n);
      chk("bus reset delay", 12'h001, 12'(n >= UD - 2 && n <= UD + 4));
      do_reset();
      // main, subordinate, paired subordinate
      for (i = 0; i < 3; i++) begin
         c = '0;
         c.role = i == 0 ? SPF_ROLE_MAIN : SPF_ROLE_SUB;
         c.paired = i == 2;
         cfg_put(c);
         chk("clock pin dir", 12'({i == 1, i == 1, i != 1, i != 1}),
             12'({fs_oe, bc_oe, fs_ie, bc_ie}));
      end
      // subordinate rates, channel sizes and slot counts
      for (i = 0; i < 4; i++) begin
         c = '0;
         c.role = SPF_ROLE_SUB;
         c.rate = spf_rate_t'(i % 3);
         c.chan = spf_chan_t'(i % 3);
         c.slots_log2 = 3'(i / 2);
         cfg_put(c);
         period(0, n);
         chk("frame period", 12'(2 * half_of(c.rate) * bits_of(c)), 12'(n));
         period(1, n);
         chk("bit clock period", 12'(2 * half_of(c.rate)), 12'(n));
         chk("core clocks", 12'({fs_o, bc_o}), 12'({pref, bcc}));
      end
      c.mic_clk_sel = 1'b1;
      cfg_put(c);
      period(1, n);
      chk("mic clock period", 12'(2 * int'(`SPF_MIC_HALF_DIV)), 12'(n));
      test_done();
   end
endmodule // spf_pin_mux_bench

bind spf_pin_mux spf_pin_mux_asserts #(.SYNC_LOSS_CYC(SYNC_LOSS_CYC),
   .UNLOCK_DLY_CYC(UNLOCK_DLY_CYC)) u_chk (.CLK_SYS_I, .SYS_RST_I, .CFG_I, .CFG_WR_I,
   .CFG_VALID_O, .SERIAL_PIN_OE_O, .SERIAL_PIN_IE_O, .FRAME_SYNC_OE_O, .FRAME_SYNC_IE_O,
   .BIT_CLOCK_OE_O, .BIT_CLOCK_IE_O, .PLL_REF_O, .PLL_LOCK_O, .BUS_RST_O);
